// ---- hw/ddrpi_top.sv ----
`timescale 1ns/1ns
module ddrpi_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  // count is one bit wider than the pointers when D is a power of two, so full and empty differ
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL = CW'(D);
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic rdy_q;
  wire push = in_valid_i && rdy_q;
  wire pop = out_ready_i && (cnt_q != '0);
  assign in_ready_o = rdy_q;
  assign out_valid_o = cnt_q != '0;
  assign out_data_o = mem_q[rp_q];
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == LAST) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == LAST) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_d;
      // registered so the port comes from a flop
      rdy_q <= cnt_d != FULL;
    end
  end
endmodule

module ddrpi_top #(
  parameter int NB = 2,
  parameter int COL_W = 4
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic CKE_I,
  input wire logic ODT_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic [ddrpi_pkg::BA_W-1:0] BA_I,
  input wire logic [ddrpi_pkg::A_W-1:0] A_I,
  input wire logic WD_VALID_I,
  output logic WD_READY_O,
  input wire logic [16*NB-1:0] WD_I,
  input wire logic [2*NB-1:0] WM_I,
  output logic [16*NB-1:0] DQ_O,
  output logic DQ_OE_N_O,
  output logic [2*NB-1:0] DQS_O,
  output logic DQS_OE_N_O,
  output logic DQS_N_OE_N_O,
  output logic [1:0] RDQS_O,
  output logic RDQS_OE_N_O,
  output logic ODT_EN_O,
  output logic CLK_EN_O,
  output logic CK_BUF_EN_O,
  output logic IN_BUF_EN_O,
  output logic OUT_DRV_EN_O,
  output logic [1:0] PWR_STATE_O,
  output logic [ddrpi_pkg::NBANK-1:0] BANK_OPEN_O,
  output logic [ddrpi_pkg::A_W-1:0] ACT_ROW_O
);
  localparam int DW = 8 * NB;
  localparam int MW = 2 * DW;
  localparam int LN = 2 * NB;
  localparam int MAW = ddrpi_pkg::BA_W + COL_W;
  localparam int MD = 1 << MAW;
  localparam int FW = MW + LN;

  function automatic logic is_cmd(input logic [3:0] c, input logic [3:0] w);
    return c == w;
  endfunction

  // two-flop capture of every pin
  logic [ddrpi_pkg::PIN_W-1:0] pin_s1_q;
  logic [ddrpi_pkg::PIN_W-1:0] pin_s2_q;
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      pin_s1_q <= ddrpi_pkg::PIN_RST;
      pin_s2_q <= ddrpi_pkg::PIN_RST;
    end else begin
      pin_s1_q <= {CKE_I, ODT_I, CS_N_I, RAS_N_I, CAS_N_I, WE_N_I, BA_I, A_I};
      pin_s2_q <= pin_s1_q;
    end
  end

  wire cke = pin_s2_q[ddrpi_pkg::P_CKE];
  wire odt = pin_s2_q[ddrpi_pkg::P_ODT];
  wire [3:0] cmd = pin_s2_q[ddrpi_pkg::P_CMD +: 4];
  wire [ddrpi_pkg::BA_W-1:0] ba = pin_s2_q[ddrpi_pkg::P_BA +: ddrpi_pkg::BA_W];
  wire [ddrpi_pkg::A_W-1:0] a = pin_s2_q[ddrpi_pkg::A_W-1:0];
  wire ap = a[ddrpi_pkg::A_AP];

  logic cke_d1_q;
  ddrpi_pkg::ddrpi_pwr_t pwr_q;
  ddrpi_pkg::ddrpi_pwr_t pwr_d;
  logic [ddrpi_pkg::NBANK-1:0] open_q;
  logic [ddrpi_pkg::A_W-1:0] row_q;
  logic [ddrpi_pkg::A_W-1:0] mr_q [ddrpi_pkg::NMR];

  wire any_open = |open_q;
  wire cke_fall = cke_d1_q && !cke;
  // commands count only with the part awake on both edges
  wire run = (pwr_q == ddrpi_pkg::PW_ACT) && cke && cke_d1_q;
  // cs_n sits in the code, so a high chip select matches nothing
  wire c_mrs = run && is_cmd(cmd, ddrpi_pkg::CMD_MRS);
  // refresh is decoded without run: it only matters as cke falls
  wire c_ref = is_cmd(cmd, ddrpi_pkg::CMD_REF);
  wire sref_ok = !any_open && c_ref;
  wire c_pre = run && is_cmd(cmd, ddrpi_pkg::CMD_PRE);
  wire c_act = run && is_cmd(cmd, ddrpi_pkg::CMD_ACT);
  wire c_wr = run && is_cmd(cmd, ddrpi_pkg::CMD_WR) && open_q[ba];
  wire c_rd = run && is_cmd(cmd, ddrpi_pkg::CMD_RD) && open_q[ba];

  wire [ddrpi_pkg::A_W-1:0] mr0 = mr_q[0];
  wire [ddrpi_pkg::A_W-1:0] emr1 = mr_q[1];
  wire [2:0] bl = mr0[ddrpi_pkg::MR_BL_LSB +: 3];
  wire [2:0] pairs = (bl == ddrpi_pkg::BL_8) ? ddrpi_pkg::PAIRS_BL8 : ddrpi_pkg::PAIRS_BL4;
  wire rtt_on = emr1[ddrpi_pkg::E1_RTT0] || emr1[ddrpi_pkg::E1_RTT1];
  wire rdqs_on = (NB == 1) && emr1[ddrpi_pkg::E1_RDQS];
  wire dqsn_on = !emr1[ddrpi_pkg::E1_DQSN_DIS];
  // column pairs: one memory word holds a rise and a fall beat
  wire [MAW-1:0] cmd_addr = {ba, a[COL_W:1]};

  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      ddrpi_pkg::PW_ACT: begin
        // entry is clocked: decided on the sampled falling edge
        if (cke_fall) begin
          if (sref_ok) begin
            pwr_d = ddrpi_pkg::PW_SREF;
          end else if (any_open) begin
            pwr_d = ddrpi_pkg::PW_APD;
          end else begin
            pwr_d = ddrpi_pkg::PW_PPD;
          end
        end
      end
      ddrpi_pkg::PW_PPD, ddrpi_pkg::PW_APD: begin
        if (cke) begin
          pwr_d = ddrpi_pkg::PW_ACT;
        end
      end
      ddrpi_pkg::PW_SREF: begin
        // exit on the level alone, no command accompanies it
        // limitation: the clock must keep running, the level is still synced
        if (cke) begin
          pwr_d = ddrpi_pkg::PW_ACT;
        end
      end
      default: begin
        pwr_d = ddrpi_pkg::PW_ACT;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      pwr_q <= ddrpi_pkg::PW_ACT;
      cke_d1_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      cke_d1_q <= cke;
    end
  end

  // buffer enables follow the next power state
  wire awake_d = (pwr_d == ddrpi_pkg::PW_ACT) && cke;
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      CLK_EN_O <= 1'b0;
      // clock buffer stays on in reset so the first edges are seen
      CK_BUF_EN_O <= 1'b1;
      IN_BUF_EN_O <= 1'b0;
      OUT_DRV_EN_O <= 1'b0;
      PWR_STATE_O <= 2'h0;
    end else begin
      CLK_EN_O <= cke;
      CK_BUF_EN_O <= pwr_d != ddrpi_pkg::PW_SREF;
      IN_BUF_EN_O <= awake_d;
      OUT_DRV_EN_O <= awake_d;
      PWR_STATE_O <= pwr_d;
    end
  end

  // bank and row bookkeeping
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      open_q <= '0;
      row_q <= '0;
    end else begin
      if (c_act) begin
        open_q[ba] <= 1'b1;
        row_q <= a;
      end else if (c_pre) begin
        if (ap) begin
          open_q <= '0;
        end else begin
          open_q[ba] <= 1'b0;
        end
      end else if ((c_rd || c_wr) && ap) begin
        // auto-precharge closes at once; burst address and count latch on the same edge
        open_q[ba] <= 1'b0;
      end
    end
  end

  // mode registers, selected by the bank code
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      for (int i = 0; i < ddrpi_pkg::NMR; i++) begin
        mr_q[i] <= ddrpi_pkg::MR_RST;
      end
    end else if (c_mrs) begin
      // bank codes four and up match no register and are dropped
      if (ba == ddrpi_pkg::SEL_MR) begin
        mr_q[0] <= a;
      end else if (ba == ddrpi_pkg::SEL_EMR1) begin
        mr_q[1] <= a;
      end else if (ba == ddrpi_pkg::SEL_EMR2) begin
        mr_q[2] <= a;
      end else if (ba == ddrpi_pkg::SEL_EMR3) begin
        mr_q[3] <= a;
      end
    end
  end

  // write beats arrive strobe-captured, centred by the controller
  logic f_valid;
  logic f_ready;
  logic [FW-1:0] f_data;
  logic [MAW-1:0] wr_ptr_q;
  logic [2:0] wr_left_q;
  logic [MAW-1:0] rd_ptr_q;
  logic [2:0] rd_left_q;
  logic [MW-1:0] mem_q [MD];

  // a read owns the array, so pending write beats back up into the fifo
  assign f_ready = (wr_left_q != '0) && (rd_left_q == '0);
  wire wr_fire = f_valid && f_ready;
  wire [MW-1:0] wd = f_data[FW-1:LN];
  // with the pin turned strobe, masking is off
  wire [LN-1:0] wm = f_data[LN-1:0] & {LN{!rdqs_on}};

  ddrpi_fifo #(
    .W(FW),
    .D(ddrpi_pkg::FIFO_DEPTH)
  ) u_wfifo (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .in_valid_i(WD_VALID_I),
    .in_ready_o(WD_READY_O),
    .in_data_i({WD_I, WM_I}),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );

  // lane i of a word: rise beats in the upper half, mask per edge
  always_ff @(posedge CLK_SYS_I) begin
    if (wr_fire) begin
      for (int i = 0; i < LN; i++) begin
        if (!wm[i]) begin
          mem_q[wr_ptr_q][8*i +: 8] <= wd[8*i +: 8];
        end
      end
    end
  end

  // burst counters; cke is trusted high while they run
  // a new command restarts its count, cutting any unfinished burst
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      wr_ptr_q <= '0;
      wr_left_q <= '0;
      rd_ptr_q <= '0;
      rd_left_q <= '0;
    end else begin
      if (c_wr) begin
        wr_ptr_q <= cmd_addr;
        wr_left_q <= pairs;
      end else if (wr_fire) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
        wr_left_q <= wr_left_q - 1'b1;
      end
      if (c_rd) begin
        rd_ptr_q <= cmd_addr;
        rd_left_q <= pairs;
      end else if (rd_left_q != '0) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        rd_left_q <= rd_left_q - 1'b1;
      end
    end
  end

  wire rd_go = rd_left_q != '0;
  // strobe high in the rise half, low in the fall half: edges on data edges
  wire [LN-1:0] dqs_pat = {{NB{1'b1}}, {NB{1'b0}}};
  wire [MW-1:0] dq_d = rd_go ? mem_q[rd_ptr_q] : '0;
  wire [LN-1:0] dqs_d = rd_go ? dqs_pat : '0;
  // the mask pin turned strobe toggles once per clock like the data strobes
  wire [1:0] rdqs_d = (rd_go && rdqs_on) ? 2'h2 : 2'h0;

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      DQ_O <= '0;
      DQ_OE_N_O <= 1'b1;
      DQS_O <= '0;
      DQS_OE_N_O <= 1'b1;
      DQS_N_OE_N_O <= 1'b1;
      RDQS_O <= 2'h0;
      RDQS_OE_N_O <= 1'b1;
    end else begin
      // upper lanes of each half belong to the upper strobe
      DQ_O <= dq_d;
      DQ_OE_N_O <= !rd_go;
      DQS_O <= dqs_d;
      DQS_OE_N_O <= !rd_go;
      DQS_N_OE_N_O <= !(rd_go && dqsn_on);
      RDQS_O <= rdqs_d;
      RDQS_OE_N_O <= !(rd_go && rdqs_on);
    end
  end

  // termination pin is a dead input in self-refresh
  wire odt_d = odt && rtt_on && (pwr_d != ddrpi_pkg::PW_SREF);
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      ODT_EN_O <= 1'b0;
      BANK_OPEN_O <= '0;
      ACT_ROW_O <= '0;
    end else begin
      ODT_EN_O <= odt_d;
      BANK_OPEN_O <= open_q;
      ACT_ROW_O <= row_q;
    end
  end
endmodule

// ---- hw/ddrpi_pkg.sv ----
// Operation
// - capture address and control pins on the rising clock edge
// - read data leaves as a rise word and a fall word per clock
// - clock enable high powers clocks, input buffers and drivers; low stops them
// - clock enable falling picks precharge power-down, self-refresh or active power-down
// - clock enable is clocked for entries; self-refresh exit needs no command
// - power-down keeps clock, termination, cke inputs; self-refresh keeps cke only
// - chip select high masks any command; it is part of the command code
// - command decoded from row strobe, column strobe, write enable and chip select
// - write beat with mask high is not stored; mask taken on both edges
// - byte-wide part: mask pin is write mask or read strobe, set by EMR1
// - bank inputs pick the bank for activate, read, write, single precharge
// - bank inputs pick which mode register a mode register set writes
// - activate takes row; read or write takes column and auto-precharge bit
// - precharge: address bit ten low closes one bank, high closes all
// - mode register set loads its operating code from the address inputs
// - device sends strobe edge-aligned with read data; controller centres write strobe
// - lower strobe qualifies the low data byte, upper strobe the high byte
// - EMR1 bit enables or disables the complementary strobe signals
// - registered termination control high switches on data, strobe, mask termination
// - termination control ignored while EMR1 has termination disabled
// - all bank bits low with the set command writes the main mode register
// - bank code two selects EMR2, bank code three selects EMR3
package ddrpi_pkg;
  localparam int BA_W = 3;
  localparam int A_W = 14;
  localparam int NBANK = 8;
  localparam int NMR = 4;
  localparam int PIN_W = 6 + BA_W + A_W;
  // cke low, odt low, command lines deselected
  localparam logic [PIN_W-1:0] PIN_RST = 23'h1e0000;
  localparam int P_CKE = 22;
  localparam int P_ODT = 21;
  localparam int P_CMD = 17;
  localparam int P_BA = 14;
  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  // mode register selects {ba2, ba1, ba0}
  localparam logic [2:0] SEL_MR = 3'h0;
  localparam logic [2:0] SEL_EMR1 = 3'h1;
  localparam logic [2:0] SEL_EMR2 = 3'h2;
  localparam logic [2:0] SEL_EMR3 = 3'h3;
  localparam int A_AP = 10;
  localparam int MR_BL_LSB = 0;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] PAIRS_BL4 = 3'h2;
  localparam logic [2:0] PAIRS_BL8 = 3'h4;
  localparam int E1_RTT0 = 2;
  localparam int E1_RTT1 = 6;
  localparam int E1_DQSN_DIS = 10;
  localparam int E1_RDQS = 11;
  localparam logic [A_W-1:0] MR_RST = 14'h0000;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [1:0] {
    PW_ACT = 2'h0,
    PW_PPD = 2'h1,
    PW_SREF = 2'h3,
    PW_APD = 2'h2
  } ddrpi_pwr_t;
endpackage

// ---- sim/ddrpi_ctl.sv ----
`timescale 1ns/1ns
module ddrpi_ctl #(
  parameter int NB = 2
) (
  input wire logic clk_i,
  input wire logic wd_ready_i,
  output logic cke_o,
  output logic odt_o,
  output logic [3:0] cmd_o,
  output logic [ddrpi_pkg::BA_W-1:0] ba_o,
  output logic [ddrpi_pkg::A_W-1:0] a_o,
  output logic wd_valid_o,
  output logic [16*NB-1:0] wd_o,
  output logic [2*NB-1:0] wm_o
);
  initial begin
    cke_o = 1'b0;
    odt_o = 1'b0;
    cmd_o = 4'hf;
    ba_o = 3'h0;
    a_o = 14'h0000;
    wd_valid_o = 1'b0;
    wd_o = '0;
    wm_o = '0;
  end
  // caller keeps cke high across every access burst
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
                     input logic k);
    @(negedge clk_i);
    cke_o = k;
    cmd_o = c;
    ba_o = b;
    a_o = a;
    @(negedge clk_i);
    cmd_o = 4'hf;
    // lines no longer meaningful, so show the inverse instead of the old value
    ba_o = ~b;
    a_o = ~a;
  endtask
  task automatic odt_set(input logic o);
    odt_o = o;
  endtask
  task automatic push(input logic [16*NB-1:0] d, input logic [2*NB-1:0] m);
    @(negedge clk_i);
    wd_valid_o = 1'b1;
    wd_o = d;
    wm_o = m;
    while (wd_ready_i !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
    wd_valid_o = 1'b0;
    wd_o = ~d;
    wm_o = ~m;
  endtask
endmodule

// ---- sim/ddrpi_top_assertions.sv ----
`timescale 1ns/1ns
module ddrpi_chk #(
  parameter int NB = 2
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic CKE_I,
  input wire logic ODT_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic [ddrpi_pkg::BA_W-1:0] BA_I,
  input wire logic [ddrpi_pkg::A_W-1:0] A_I,
  input wire logic DQ_OE_N_O,
  input wire logic [2*NB-1:0] DQS_O,
  input wire logic DQS_OE_N_O,
  input wire logic DQS_N_OE_N_O,
  input wire logic ODT_EN_O,
  input wire logic CK_BUF_EN_O,
  input wire logic IN_BUF_EN_O,
  input wire logic OUT_DRV_EN_O,
  input wire logic [1:0] PWR_STATE_O,
  input wire logic [ddrpi_pkg::NBANK-1:0] BANK_OPEN_O,
  input wire logic [ddrpi_pkg::A_W-1:0] ACT_ROW_O
);
  // commands count only after cke has been high through the sync pipe
  logic [1:0] cke_run_q;
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I || !CKE_I) cke_run_q <= 2'h0;
    else if (cke_run_q != 2'h3) cke_run_q <= cke_run_q + 2'h1;
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);
  chk_dqs_read_shape: assert property (!DQS_OE_N_O |->
    (DQS_O == {{NB{1'b1}}, {NB{1'b0}}} && !DQ_OE_N_O)) else $error("strobe shape bad");
  chk_dqsn_follows: assert property (!DQS_N_OE_N_O |-> !DQS_OE_N_O)
    else $error("complement strobe alone");
  chk_burst_pairs: assert property ($fell(DQ_OE_N_O) |-> ##1 !DQ_OE_N_O)
    else $error("read burst too short");
  chk_sref_clock: assert property ((PWR_STATE_O == 2'h3) == !CK_BUF_EN_O)
    else $error("clock buffer state bad");
  chk_buf_pair: assert property (IN_BUF_EN_O == OUT_DRV_EN_O)
    else $error("buffers and drivers differ");
  chk_buf_active: assert property (IN_BUF_EN_O |-> PWR_STATE_O == 2'h0)
    else $error("input buffers on while asleep");
  chk_cs_ignored: assert property (CS_N_I |-> ##4 $stable(BANK_OPEN_O))
    else $error("deselected command acted");
  chk_cke_low_idle: assert property (!CKE_I [*3] |-> ##4 $stable(BANK_OPEN_O))
    else $error("command acted with cke low");
  chk_act_opens: assert property ((CKE_I && cke_run_q == 2'h3 &&
    {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I} == ddrpi_pkg::CMD_ACT) |-> ##4
    (BANK_OPEN_O[$past(BA_I, 4)] && ACT_ROW_O == $past(A_I, 4))) else $error("activate lost");
  chk_odt_off: assert property (!ODT_I [*6] |=> !ODT_EN_O)
    else $error("termination on without odt");
endmodule
bind ddrpi_top ddrpi_chk #(.NB(NB)) ddrpi_chk_i (.CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I),
  .CKE_I(CKE_I), .ODT_I(ODT_I), .CS_N_I(CS_N_I), .RAS_N_I(RAS_N_I), .CAS_N_I(CAS_N_I),
  .WE_N_I(WE_N_I), .BA_I(BA_I), .A_I(A_I), .DQ_OE_N_O(DQ_OE_N_O), .DQS_O(DQS_O),
  .DQS_OE_N_O(DQS_OE_N_O), .DQS_N_OE_N_O(DQS_N_OE_N_O), .ODT_EN_O(ODT_EN_O),
  .CK_BUF_EN_O(CK_BUF_EN_O), .IN_BUF_EN_O(IN_BUF_EN_O), .OUT_DRV_EN_O(OUT_DRV_EN_O),
  .PWR_STATE_O(PWR_STATE_O), .BANK_OPEN_O(BANK_OPEN_O), .ACT_ROW_O(ACT_ROW_O));

// ---- sim/tb.sv ----
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cke, odt, wdv, wdr, dq_oe_n, dqs_oe_n, dqsn_oe_n, rdqs_oe_n, odt_en, clk_en;
  logic ck_buf, in_buf;
  logic [3:0] c, wm, dqs;
  logic [2:0] ba;
  logic [13:0] a, row, exp_row;
  logic [31:0] wd, dq;
  logic [1:0] pwr, rdqs;
  logic [7:0] bopen;
  int n_errors = 0;
  int compares = 0;
  // {command, bank, address, expected open banks}
  localparam logic [28:0] ROWS [7] = '{
    {ddrpi_pkg::CMD_ACT, 3'h1, 14'h1234, 8'h02}, {ddrpi_pkg::CMD_ACT, 3'h5, 14'h0abc, 8'h22},
    {4'hb, 3'h3, 14'h0111, 8'h22}, {ddrpi_pkg::CMD_PRE, 3'h1, 14'h0000, 8'h20},
    {ddrpi_pkg::CMD_ACT, 3'h2, 14'h2001, 8'h24}, {ddrpi_pkg::CMD_PRE, 3'h0, 14'h0400, 8'h00},
    {ddrpi_pkg::CMD_ACT, 3'h7, 14'h3fff, 8'h80}};
  // column pairs 0 to 3 of bank 7 as the write scenarios leave them
  localparam logic [31:0] BL8 [4] = '{32'haabbcc44, 32'h55ff0011, 32'h00000000, 32'h00000001};
  always #50 clk = ~clk;
  ddrpi_top #(.NB(2), .COL_W(4)) ddrpi_top_i (.CLK_SYS_I(clk), .RESET_I(rst), .CKE_I(cke),
    .ODT_I(odt), .CS_N_I(c[3]), .RAS_N_I(c[2]), .CAS_N_I(c[1]), .WE_N_I(c[0]), .BA_I(ba),
    .A_I(a), .WD_VALID_I(wdv), .WD_READY_O(wdr), .WD_I(wd), .WM_I(wm), .DQ_O(dq),
    .DQ_OE_N_O(dq_oe_n), .DQS_O(dqs), .DQS_OE_N_O(dqs_oe_n), .DQS_N_OE_N_O(dqsn_oe_n),
    .RDQS_O(rdqs), .RDQS_OE_N_O(rdqs_oe_n), .ODT_EN_O(odt_en), .CLK_EN_O(clk_en),
    .CK_BUF_EN_O(ck_buf), .IN_BUF_EN_O(in_buf), .OUT_DRV_EN_O(), .PWR_STATE_O(pwr),
    .BANK_OPEN_O(bopen), .ACT_ROW_O(row));
  ddrpi_ctl #(.NB(2)) ddrpi_ctl_i (.clk_i(clk), .wd_ready_i(wdr), .cke_o(cke), .odt_o(odt),
    .cmd_o(c), .ba_o(ba), .a_o(a), .wd_valid_o(wdv), .wd_o(wd), .wm_o(wm));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic mrs(input logic [2:0] sel, input logic [13:0] code);
    ddrpi_ctl_i.cmd(ddrpi_pkg::CMD_MRS, sel, code, 1'b1);
    repeat (4) @(negedge clk);
  endtask
  task automatic rd(input logic [31:0] e0, input logic [31:0] e1, input logic en);
    ddrpi_ctl_i.cmd(ddrpi_pkg::CMD_RD, 3'h7, 14'h0000, 1'b1);
    repeat (3) @(negedge clk);
    chk(dq, e0);
    chk(dqs, 4'hc);
    chk(dqsn_oe_n, en);
    chk(rdqs_oe_n, 1'b1);
    chk(rdqs, 2'h0);
    @(negedge clk);
    chk(dq, e1);
    @(negedge clk);
    chk(dq_oe_n, 1'b1);
  endtask
  task automatic pw(input logic [3:0] cc, input logic k, input logic [1:0] ep, input logic eb);
    ddrpi_ctl_i.cmd(cc, 3'h0, 14'h0000, k);
    repeat (4) @(negedge clk);
    chk(pwr, ep);
    chk(in_buf, ep == 2'h0);
    chk(ck_buf, eb);
  endtask
  initial begin
    @(negedge clk);
    chk({ck_buf, dq_oe_n, wdr, clk_en}, 4'hc);
    @(negedge clk);
    rst = 1'b0;
    ddrpi_ctl_i.cmd(4'hf, 3'h0, 14'h0000, 1'b1);
    repeat (4) @(negedge clk);
    chk(clk_en, 1'b1);
    mrs(ddrpi_pkg::SEL_MR, 14'h0000);
    mrs(ddrpi_pkg::SEL_EMR2, 14'h0000);
    mrs(ddrpi_pkg::SEL_EMR3, 14'h0000);
    mrs(ddrpi_pkg::SEL_EMR1, 14'h0004);
    ddrpi_ctl_i.odt_set(1'b1);
    repeat (6) @(negedge clk);
    chk(odt_en, 1'b1);
    mrs(ddrpi_pkg::SEL_EMR1, 14'h0000);
    repeat (2) @(negedge clk);
    chk(odt_en, 1'b0);
    ddrpi_ctl_i.odt_set(1'b0);
    exp_row = 14'h0000;
    for (int i = 0; i < 7; i++) begin
      ddrpi_ctl_i.cmd(ROWS[i][28:25], ROWS[i][24:22], ROWS[i][21:8], 1'b1);
      if (ROWS[i][28:25] == ddrpi_pkg::CMD_ACT) exp_row = ROWS[i][21:8];
      repeat (4) @(negedge clk);
      chk(bopen, ROWS[i][7:0]);
      chk(row, exp_row);
    end
    $display("command table done");
    for (int i = 0; i < 8; i++) ddrpi_ctl_i.push(32'(i), 4'h0);
    @(negedge clk);
    chk(wdr, 1'b0);
    for (int i = 1; i < 5; i++) begin
      ddrpi_ctl_i.cmd(ddrpi_pkg::CMD_WR, 3'h7, 14'(4 * i), 1'b1);
      repeat (4) @(negedge clk);
      chk(wdr, 1'b1);
    end
    $display("buffer fill and drain done");
    ddrpi_ctl_i.push(32'h11223344, 4'h0);
    ddrpi_ctl_i.push(32'h55667788, 4'h0);
    ddrpi_ctl_i.cmd(ddrpi_pkg::CMD_WR, 3'h7, 14'h0000, 1'b1);
    ddrpi_ctl_i.push(32'haabbccdd, 4'h1);
    ddrpi_ctl_i.push(32'heeff0011, 4'h8);
    ddrpi_ctl_i.cmd(ddrpi_pkg::CMD_WR, 3'h7, 14'h0000, 1'b1);
    repeat (6) @(negedge clk);
    rd(32'haabbcc44, 32'h55ff0011, 1'b0);
    mrs(ddrpi_pkg::SEL_EMR1, 14'h0400);
    rd(32'haabbcc44, 32'h55ff0011, 1'b1);
    $display("masked write and read done");
    pw(4'hf, 1'b0, 2'h2, 1'b1);
    pw(4'hf, 1'b1, 2'h0, 1'b1);
    ddrpi_ctl_i.cmd(ddrpi_pkg::CMD_PRE, 3'h0, 14'h0400, 1'b1);
    repeat (4) @(negedge clk);
    pw(4'hf, 1'b0, 2'h1, 1'b1);
    pw(4'hf, 1'b1, 2'h0, 1'b1);
    pw(ddrpi_pkg::CMD_REF, 1'b0, 2'h3, 1'b0);
    pw(4'hf, 1'b1, 2'h0, 1'b1);
    $display("power states done");
    mrs(ddrpi_pkg::SEL_MR, 14'h0003);
    ddrpi_ctl_i.cmd(ddrpi_pkg::CMD_ACT, 3'h7, 14'h0001, 1'b1);
    ddrpi_ctl_i.cmd(ddrpi_pkg::CMD_RD, 3'h7, 14'h0400, 1'b1);
    repeat (3) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      chk(dq, BL8[i]);
      @(negedge clk);
    end
    chk({dq_oe_n, bopen}, 9'h100);
    $display("long burst with auto-precharge done");
    stop_test();
  end
  initial begin
    #400000;
    n_errors++;
    $display("watchdog expired");
    stop_test();
  end
endmodule
